// ---- core/gdf_duty_gen.sv ----
// duty-cycle pulse generator encoding an adc reading
`default_nettype none
module gdf_duty_gen
   import gdf_pkg::*;
#(
   parameter int ADC_W = GDF_ADC_W
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // value in, pulse out
   gdf_duty_if.gen duty
);
   // refuse widths the counter and compare cannot serve
   if (ADC_W < 2 || ADC_W > 16) begin : g_bad_adc_w
      $error("gdf_duty_gen: ADC_W out of range");
   end

   typedef struct packed {
      logic [ADC_W-1:0] cnt;
      logic [ADC_W-1:0] val;
      logic pulse;
   } gdf_duty_st_t;

   gdf_duty_st_t st_reg;
   gdf_duty_st_t st_next;

   // ==========================================================
   // period counter; value is latched per period so the duty
   // never tears mid-cycle
   always_comb begin
      st_next = st_reg;
      st_next.cnt = st_reg.cnt + ADC_W'(1);
      if (st_reg.cnt == '1) begin
         st_next.val = duty.value;
      end
      st_next.pulse = (st_next.cnt < st_next.val);
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign duty.pulse = st_reg.pulse;

   // at each period start the new value is taken and a zero value stays low
   a_duty_high_low: assert property (@(posedge i_clk) disable iff (i_rst)
      (st_reg.cnt == '1) |=> (st_reg.val == $past(duty.value))
      && (st_reg.pulse == (st_reg.val != '0)))
      else $error("duty pulse does not match value");
endmodule : gdf_duty_gen
`default_nettype wire

// ---- core/gdf_input_fault.sv ----
// gate drive input resolution and fault indicator logic
`default_nettype none
module gdf_input_fault
   import gdf_pkg::*;
#(
   parameter int NUM_FAULTS = GDF_NUM_FAULTS,
   parameter int ADC_W = GDF_ADC_W
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // drive control
   input wire logic i_driver_enable,
   input wire logic i_pwm_pos,
   input wire logic i_pwm_neg,
   input wire logic i_short_circuit_override_enable,
   input wire logic i_short_circuit_override_level,
   // fault sources, masks and routing
   input wire logic [NUM_FAULTS-1:0] i_faults,
   input wire logic [NUM_FAULTS-1:0] i_alarm_mask,
   input wire logic [NUM_FAULTS-1:0] i_warning_mask,
   input wire logic [NUM_FAULTS-1:0] i_route_to_warning,
   // duty output selection
   input wire logic i_duty_mode,
   input wire logic [ADC_W-1:0] i_adc_value,
   // drive outputs
   output logic o_pull_up_output,
   output logic o_pull_down_output,
   // indicators and status
   output logic o_fault_alarm_n,
   output logic o_fault_warning_n,
   output logic o_overlap_fault
);
   // the overlap fault needs its own slot inside the fault vector
   if (NUM_FAULTS < 1 || NUM_FAULTS > 32
       || NUM_FAULTS <= GDF_FAULT_OVERLAP) begin : g_bad_faults
      $error("gdf_input_fault: NUM_FAULTS out of range");
   end

   typedef struct packed {
      gdf_mode_t mode;
      logic up;
      logic dn;
      logic overlap;
      logic alarm_n;
      logic warning_n;
   } gdf_st_t;

   gdf_st_t st_reg;
   gdf_st_t st_next;
   logic [NUM_FAULTS-1:0] all_faults;
   logic [NUM_FAULTS-1:0] alarm_act;
   logic [NUM_FAULTS-1:0] warning_act;

   gdf_duty_if #(.ADC_W(ADC_W)) duty ();

   // ==========================================================
   // duty generator for the warning pin's alternate function
   gdf_duty_gen #(.ADC_W(ADC_W)) u_duty (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .duty(duty)
   );
   assign duty.value = i_adc_value;

   // ==========================================================
   // fault routing; overlap is injected into its own slot
   always_comb begin
      all_faults = i_faults;
      all_faults[GDF_FAULT_OVERLAP] = i_faults[GDF_FAULT_OVERLAP]
         | (i_pwm_pos & i_pwm_neg);
   end

   // per-fault gating, one slice per source
   for (genvar g = 0; g < NUM_FAULTS; g++) begin : g_route
      assign alarm_act[g] = all_faults[g] & ~i_route_to_warning[g]
         & ~i_alarm_mask[g];
      assign warning_act[g] = all_faults[g] & i_route_to_warning[g]
         & ~i_warning_mask[g];
   end

   // ==========================================================
   // drive resolution; override outranks the overlap pull-down so an
   // active short circuit is never defeated by a pwm glitch
   always_comb begin
      st_next = st_reg;
      st_next.overlap = i_pwm_pos & i_pwm_neg;
      if (i_short_circuit_override_enable) begin
         st_next.mode = GDF_MODE_OVERRIDE;
      end else if (st_next.overlap) begin
         st_next.mode = GDF_MODE_OVERLAP;
      end else if (i_driver_enable) begin
         st_next.mode = GDF_MODE_PWM;
      end else begin
         st_next.mode = GDF_MODE_OFF;
      end
      unique case (st_next.mode)
         GDF_MODE_OVERRIDE: begin
            st_next.up = i_short_circuit_override_level;
            st_next.dn = ~i_short_circuit_override_level;
         end
         GDF_MODE_OVERLAP: begin
            st_next.up = 1'b0;
            st_next.dn = 1'b1;
         end
         GDF_MODE_PWM: begin
            st_next.up = i_pwm_pos;
            st_next.dn = ~i_pwm_pos;
         end
         GDF_MODE_OFF: begin
            st_next.up = 1'b0;
            st_next.dn = 1'b1;
         end
      endcase
      st_next.alarm_n = ~|alarm_act;
      st_next.warning_n = ~|warning_act;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg.mode <= GDF_MODE_OFF;
         st_reg.up <= GDF_RST_UP;
         st_reg.dn <= GDF_RST_DN;
         st_reg.overlap <= 1'b0;
         st_reg.alarm_n <= GDF_RST_IND;
         st_reg.warning_n <= GDF_RST_IND;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // outputs; the warning pin picks duty or fault level
   assign o_pull_up_output = st_reg.up;
   assign o_pull_down_output = st_reg.dn;
   assign o_overlap_fault = st_reg.overlap;
   assign o_fault_alarm_n = st_reg.alarm_n;
   assign o_fault_warning_n = i_duty_mode ? duty.pulse
      : st_reg.warning_n;

   // ==========================================================
   // checks
   sequence s_override_req;
      i_short_circuit_override_enable;
   endsequence

   a_override_level: assert property (@(posedge i_clk) disable iff (i_rst)
      s_override_req ##1 1'b1 |-> o_pull_up_output ==
      $past(i_short_circuit_override_level))
      else $error("override level not followed");
   a_override_both: assert property (@(posedge i_clk) disable iff (i_rst)
      s_override_req |=> o_pull_down_output ==
      !$past(i_short_circuit_override_level))
      else $error("override drives both or neither");
   a_pwm_follow: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_driver_enable && !i_short_circuit_override_enable && !i_pwm_neg)
      |=> o_pull_up_output == $past(i_pwm_pos)
      && o_pull_down_output == !$past(i_pwm_pos))
      else $error("pwm not followed");
   a_overlap_flag: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_pwm_pos && i_pwm_neg) |=> o_overlap_fault)
      else $error("overlap not flagged");
   a_overlap_pull_dn: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_pwm_pos && i_pwm_neg && !i_short_circuit_override_enable)
      |=> o_pull_down_output && !o_pull_up_output)
      else $error("overlap did not pull down");
   a_alarm_low: assert property (@(posedge i_clk) disable iff (i_rst)
      (|(i_faults & ~i_route_to_warning & ~i_alarm_mask))
      |=> !o_fault_alarm_n)
      else $error("alarm not raised");
   a_alarm_high: assert property (@(posedge i_clk) disable iff (i_rst)
      (!i_pwm_neg && !(|(i_faults & ~i_route_to_warning & ~i_alarm_mask)))
      |=> o_fault_alarm_n)
      else $error("alarm raised without cause");
   a_warning_low: assert property (@(posedge i_clk) disable iff (i_rst)
      (|(i_faults & i_route_to_warning & ~i_warning_mask)) ##1 !i_duty_mode
      |-> !o_fault_warning_n)
      else $error("warning not raised");
   a_warning_high: assert property (@(posedge i_clk) disable iff (i_rst)
      (!i_pwm_neg && !(|(i_faults & i_route_to_warning & ~i_warning_mask)))
      ##1 !i_duty_mode |-> o_fault_warning_n)
      else $error("warning raised without cause");
endmodule : gdf_input_fault
`default_nettype wire

// ---- inc/gdf_duty_if.sv ----
// interface carrying duty-cycle request and pulse between modules
`default_nettype none
interface gdf_duty_if #(parameter int ADC_W = 10);
   logic [ADC_W-1:0] value;
   logic pulse;
   modport src (output value, input pulse);
   modport gen (input value, output pulse);
endinterface : gdf_duty_if
`default_nettype wire

// ---- inc/gdf_pkg.sv ----
// package of constants and types for the gate drive input and fault logic
`default_nettype none
package gdf_pkg;
   // pwm frequency bounds the host must keep
   localparam int GDF_PWM_MIN_HZ = 1000;
   localparam int GDF_PWM_MAX_HZ = 50000;
   localparam int GDF_CLK_HZ = 50000000;
   // longest legal pwm period in clock cycles (rounds down)
   localparam int GDF_PWM_MAX_PERIOD_CYC = GDF_CLK_HZ / GDF_PWM_MIN_HZ;
   // default duty output period and adc width
   localparam int GDF_DUTY_PERIOD_CYC = 1024;
   localparam int GDF_ADC_W = 10;
   // fault sources on the indicator outputs
   localparam int GDF_NUM_FAULTS = 4;
   localparam int GDF_FAULT_OVERLAP = 0;
   // reset values
   localparam logic GDF_RST_UP = 1'b0;
   localparam logic GDF_RST_DN = 1'b1;
   localparam logic GDF_RST_IND = 1'b1;

   // drive resolution mode
   typedef enum logic [1:0] {
      GDF_MODE_OFF,
      GDF_MODE_PWM,
      GDF_MODE_OVERRIDE,
      GDF_MODE_OVERLAP
   } gdf_mode_t;
endpackage : gdf_pkg
`default_nettype wire

// ---- sim/gdf_host_pwm.sv ----
// host controller model that drives the own-arm pwm input
`default_nettype none
module gdf_host_pwm
   import gdf_pkg::*;
#(
   parameter int PERIOD_CYC = GDF_CLK_HZ / GDF_PWM_MAX_HZ,
   parameter int HIGH_CYC = 300
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // run request and pwm
   input wire logic i_run,
   output logic o_pwm
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_reg;
   // free-running period; pwm parks low when stopped so no stale level
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_reg <= 0;
         o_pwm <= 1'b0;
      end else begin
         cnt_reg <= (!i_run || cnt_reg == PERIOD_CYC - 1) ? 0 : cnt_reg + 1;
         o_pwm <= i_run && (cnt_reg < HIGH_CYC);
      end
   end
endmodule : gdf_host_pwm
`default_nettype wire

// ---- sim/tb_gdf_input_fault.sv ----
// self-checking bench for the gate drive input and fault logic
`default_nettype none
module tb_gdf_input_fault;
   import gdf_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // signals and instances
   logic i_clk = 1'b0, i_rst = 1'b1, en = 1'b0, pos = 1'b0, neg = 1'b0;
   logic ov_en = 1'b0, ov_lvl = 1'b0, duty = 1'b0, run = 1'b0;
   logic [3:0] flt = 4'h0, am = 4'h0, wm = 4'h0, rt = 4'h0;
   logic [9:0] adc = 10'h000;
   logic up, dn, al_n, wr_n, ovl, hpwm, pwm_pos;
   int failures = 0, num_checks = 0, cycles = 0;
   // the host model owns the pwm line while it runs
   assign pwm_pos = run ? hpwm : pos;
   gdf_host_pwm u_gdf_host_pwm (.i_clk(i_clk), .i_rst(i_rst),
      .i_run(run), .o_pwm(hpwm));
   gdf_input_fault u_gdf_input_fault (.i_clk(i_clk), .i_rst(i_rst),
      .i_driver_enable(en), .i_pwm_pos(pwm_pos), .i_pwm_neg(neg),
      .i_short_circuit_override_enable(ov_en),
      .i_short_circuit_override_level(ov_lvl), .i_faults(flt),
      .i_alarm_mask(am), .i_warning_mask(wm), .i_route_to_warning(rt),
      .i_duty_mode(duty), .i_adc_value(adc), .o_pull_up_output(up),
      .o_pull_down_output(dn), .o_fault_alarm_n(al_n),
      .o_fault_warning_n(wr_n), .o_overlap_fault(ovl));
   always #10 i_clk = ~i_clk;
   // ==========================================================
   // shared tasks; inputs move 1 ns after the edge, away from sampling
   task automatic tick();
      @(posedge i_clk);
      #1;
   endtask : tick
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask : chk
   task automatic results();
      if (failures == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : results
   // ==========================================================
   // scenarios
   task automatic t_drive();
      logic e;
      for (int i = 0; i < 32; i++) begin
         {en, pos, neg, ov_en, ov_lvl} = i[4:0];
         tick();
         e = ov_en ? ov_lvl : (en && pos && !neg);
         chk({up, dn}, {e, !e});
         chk({ovl, al_n}, {pos & neg, !(pos & neg)});
      end
      // drop the override so later scenarios see plain pwm control
      {en, pos, neg, ov_en, ov_lvl} = 5'h00;
   endtask : t_drive
   task automatic t_faults();
      logic [3:0] f;
      for (int i = 0; i < 1024; i++) begin
         {neg, pos} = {i[9], i[9]};
         am = i[8] ? 4'h3 : 4'h0;
         wm = i[8] ? 4'h9 : 4'h0;
         rt = i[7:4];
         flt = i[3:0];
         tick();
         f = flt | {3'h0, i[9]};
         chk(al_n, !(|(f & ~rt & ~am)));
         chk(wr_n, !(|(f & rt & ~wm)));
      end
      {neg, pos, flt} = 6'h00;
   endtask : t_faults
   task automatic t_duty(input logic [9:0] val);
      int highs = 0;
      duty = 1'b1;
      adc = val;
      // two periods let the new value be latched at a period end
      repeat (2 * GDF_DUTY_PERIOD_CYC) tick();
      for (int c = 0; c < GDF_DUTY_PERIOD_CYC; c++) begin
         tick();
         highs += int'(wr_n === 1'b1);
      end
      chk(highs[9:0], val);
      duty = 1'b0;
   endtask : t_duty
   task automatic t_host();
      logic prev;
      en = 1'b1;
      run = 1'b1;
      tick();
      prev = pwm_pos;
      for (int c = 0; c < 2000; c++) begin
         tick();
         chk({up, dn}, {prev, !prev});
         prev = pwm_pos;
      end
      run = 1'b0;
   endtask : t_host
   task automatic t_reset();
      {en, pos, flt} = 6'h3f;
      tick();
      i_rst = 1'b1;
      tick();
      chk({up, dn, al_n, wr_n, ovl},
          {GDF_RST_UP, GDF_RST_DN, GDF_RST_IND, GDF_RST_IND, 1'b0});
      i_rst = 1'b0;
      tick();
      chk({up, dn, al_n, wr_n}, 4'ha);
   endtask : t_reset
   // ==========================================================
   // hang guard and main sequence
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         results();
      end
   end
   initial begin
      repeat (10) @(posedge i_clk);
      #1;
      i_rst = 1'b0;
      tick();
      t_drive();
      t_faults();
      t_duty(10'h000);
      t_duty(10'h12c);
      t_duty(10'h3ff);
      t_host();
      t_reset();
      results();
   end
endmodule : tb_gdf_input_fault
`default_nettype wire
